// ### pmp_pkg.sv
package pmp_pkg;
  // management register addresses
  localparam logic [4:0] REG_INT_CTRL = 5'h11;
  localparam logic [4:0] REG_INT_STAT = 5'h12;
  localparam logic [4:0] REG_PWR_CTRL = 5'h13;
  // interrupt control fields
  localparam int INT_EN_LSB = 0;
  localparam int INT_POL_BIT = 4;
  localparam int NUM_EVENTS = 3;
  localparam int EV_RX_ERR = 0;
  localparam int EV_TX_ERR = 1;
  localparam int EV_WAKE = 2;
  // power control fields
  localparam int PWR_SLEEP_BIT = 0;
  localparam int PWR_SGMII_BIT = 1;
  // reset values
  localparam logic [2:0] INT_EN_RST = 3'h0;
  localparam logic INT_POL_RST = 1'h0;
  // management frame
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [5:0] HDR_BITS = 6'h0e;
  localparam logic [5:0] DATA_BITS = 6'h10;
  localparam logic [1:0] FRAME_START = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  // upper management address bits not set by the strap (arbitrary value)
  localparam logic [3:0] ADDR_HI = 4'h0;
  // cycles between reset release and strap capture
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic [2:0] SER_LAST = 3'h7;

  typedef enum logic [4:0] {
    MD_PRE = 5'h01,
    MD_HDR = 5'h02,
    MD_TA = 5'h04,
    MD_RD = 5'h08,
    MD_WR = 5'h10
  } pmp_md_e;
endpackage : pmp_pkg

// ### pmp_tx_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pmp_tx_if;
  logic [7:0] data;
  logic en;
  logic er;
  logic tgl;
  modport src (output data, output en, output er, output tgl);
  modport dst (input data, input en, input er, input tgl);
endinterface : pmp_tx_if
`default_nettype wire

// ### pmp_tx_rgmii.sv
`timescale 1ns/100ps
`default_nettype none
module pmp_tx_rgmii (
  // link clock from the mac
  input wire logic tx_clk,
  input wire logic link_rst,
  // rgmii transmit pins
  input wire logic tx_ctl,
  input wire logic [3:0] tx_d,
  // toward the core domain
  pmp_tx_if.src out
);
  typedef struct packed {
    logic [3:0] lo;
    logic en;
  } pmp_rise_s;

  typedef struct packed {
    logic [7:0] data;
    logic en;
    logic er;
    logic tgl;
  } pmp_fall_s;

  pmp_rise_s rise_reg;
  pmp_fall_s fall_reg;
  pmp_fall_s fall_next;

  // rising edge: enable and low nibble
  always_ff @(posedge tx_clk) begin
    if (link_rst) begin
      rise_reg <= '0;
    end else begin
      rise_reg <= '{lo: tx_d, en: tx_ctl};
    end
  end

  // falling edge completes the byte inside the same clock period,
  // so a clock that stops after the frame still delivers the last byte
  always_comb begin
    fall_next = fall_reg;
    if (rise_reg.en || tx_ctl) begin
      fall_next.data = {tx_d, rise_reg.lo};
      fall_next.en = rise_reg.en;
      fall_next.er = rise_reg.en ^ tx_ctl;
      fall_next.tgl = ~fall_reg.tgl;
    end
  end

  always_ff @(negedge tx_clk) begin
    if (link_rst) begin
      fall_reg <= '0;
    end else begin
      fall_reg <= fall_next;
    end
  end

  assign out.data = fall_reg.data;
  assign out.en = fall_reg.en;
  assign out.er = fall_reg.er;
  assign out.tgl = fall_reg.tgl;
endmodule : pmp_tx_rgmii
`default_nettype wire

// ### pmp_port.sv
`timescale 1ns/100ps
`default_nettype none
module pmp_port (
  // core clock and hardware reset
  input wire logic clk,
  input wire logic resetn,
  // decoded cable data in
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic rx_error,
  output logic rx_ready,
  // received mac data out
  output logic [7:0] tx_byte,
  output logic tx_valid,
  output logic tx_error,
  // rgmii receive pins
  output logic rx_clk_o,
  output logic [3:0] rx_d_o,
  output logic rx_d_oe,
  input wire logic rx_ctl_i,
  output logic rx_ctl_o,
  output logic rx_ctl_oe,
  // rgmii transmit pins
  input wire logic tx_clk,
  input wire logic tx_ctl,
  input wire logic [3:0] tx_d,
  // management pins
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  // control pins
  output logic interrupt_output_o,
  output logic interrupt_output_oe,
  output logic power_inhibit_output_o,
  output logic power_inhibit_output_oe,
  input wire logic wake,
  input wire logic first_strap_pin
);
  typedef struct packed {
    // rgmii receive
    logic phase;
    logic [3:0] rxd;
    logic rxd_oe;
    logic rxctl;
    logic rxctl_oe;
    logic [3:0] hi_hold;
    logic ctl_hold;
    // sgmii serial out and in
    logic [7:0] ser_sh;
    logic [2:0] ser_cnt;
    logic [7:0] des_sh;
    logic [2:0] des_cnt;
    logic [2:0] sin_s;
    logic sin_f;
    // transmit crossing and output
    logic [2:0] tgl_s;
    logic tgl_seen;
    logic [7:0] txb;
    logic txv;
    logic txe;
    // pin synchronisers
    logic [2:0] mdc_s;
    logic mdc_f;
    logic [2:0] mdio_s;
    logic mdio_f;
    logic [2:0] wake_s;
    logic wake_f;
    logic [2:0] strap_s;
    logic [2:0] mode_s;
    // management engine
    pmp_pkg::pmp_md_e st;
    logic [5:0] cnt;
    logic [15:0] sh;
    logic [4:0] reg_addr;
    logic rd_op;
    logic mdo;
    logic mdoe;
    // control state
    logic [pmp_pkg::NUM_EVENTS-1:0] int_en;
    logic [pmp_pkg::NUM_EVENTS-1:0] int_stat;
    logic int_pol;
    logic sleep;
    // straps
    logic [1:0] strap_cnt;
    logic strap_done;
    logic sgmii;
    logic addr0;
  } pmp_state_s;

  pmp_state_s s_reg;
  pmp_state_s s_next;
  pmp_tx_if txi ();

  // link-side logic follows the core reset, synchronised to its own clock
  logic [1:0] link_rst_s;
  always_ff @(posedge tx_clk) begin
    link_rst_s <= {link_rst_s[0], ~resetn};
  end

  pmp_tx_rgmii u_tx (
    .tx_clk(tx_clk),
    .link_rst(link_rst_s[1]),
    .tx_ctl(tx_ctl),
    .tx_d(tx_d),
    .out(txi.src)
  );

  // three-flop filter: a change counts once stages two and three agree
  function automatic logic filt(input logic [2:0] s, input logic f);
    filt = (s[1] == s[2]) ? s[2] : f;
  endfunction : filt

  function automatic logic [15:0] reg_read(input pmp_state_s r, input logic [4:0] a);
    reg_read = 16'h0000;
    case (a)
      pmp_pkg::REG_INT_CTRL: begin
        reg_read[pmp_pkg::INT_EN_LSB +: pmp_pkg::NUM_EVENTS] = r.int_en;
        reg_read[pmp_pkg::INT_POL_BIT] = r.int_pol;
      end
      pmp_pkg::REG_INT_STAT: reg_read[pmp_pkg::NUM_EVENTS-1:0] = r.int_stat;
      pmp_pkg::REG_PWR_CTRL: begin
        reg_read[pmp_pkg::PWR_SLEEP_BIT] = r.sleep;
        reg_read[pmp_pkg::PWR_SGMII_BIT] = r.sgmii;
      end
      default: reg_read = 16'h0000;
    endcase
  endfunction : reg_read

  logic mdc_rise;
  logic wake_rise;
  logic tx_evt;
  logic [pmp_pkg::NUM_EVENTS-1:0] ev;
  logic [pmp_pkg::NUM_EVENTS-1:0] clr;
  logic int_active;
  logic [4:0] my_addr;
  logic [15:0] hdr;

  always_comb begin
    s_next = s_reg;
    clr = '0;
    ev = '0;
    hdr = s_reg.sh;
    my_addr = {pmp_pkg::ADDR_HI, s_reg.addr0};

    // pin synchronisers
    s_next.mdc_s = {s_reg.mdc_s[1:0], mdc};
    s_next.mdio_s = {s_reg.mdio_s[1:0], mdio_i};
    s_next.wake_s = {s_reg.wake_s[1:0], wake};
    s_next.strap_s = {s_reg.strap_s[1:0], first_strap_pin};
    s_next.mode_s = {s_reg.mode_s[1:0], rx_ctl_i};
    s_next.sin_s = {s_reg.sin_s[1:0], tx_d[1]};
    s_next.tgl_s = {s_reg.tgl_s[1:0], txi.tgl};
    s_next.mdc_f = filt(s_reg.mdc_s, s_reg.mdc_f);
    s_next.mdio_f = filt(s_reg.mdio_s, s_reg.mdio_f);
    s_next.wake_f = filt(s_reg.wake_s, s_reg.wake_f);
    s_next.sin_f = filt(s_reg.sin_s, s_reg.sin_f);
    mdc_rise = s_next.mdc_f & ~s_reg.mdc_f;
    wake_rise = s_next.wake_f & ~s_reg.wake_f;

    // straps are caught once the synchronisers have settled
    if (!s_reg.strap_done) begin
      if (s_reg.strap_cnt == pmp_pkg::STRAP_SETTLE) begin
        s_next.strap_done = 1'b1;
        s_next.addr0 = s_reg.strap_s[2];
        s_next.sgmii = s_reg.mode_s[2];
      end else begin
        s_next.strap_cnt = s_reg.strap_cnt + 2'h1;
      end
    end

    // rgmii receive: clock is core clock halved, data changes with each edge
    s_next.rxd_oe = s_reg.strap_done & ~s_reg.sgmii;
    s_next.rxctl_oe = s_reg.strap_done & ~s_reg.sgmii;
    if (s_reg.strap_done && !s_reg.sgmii) begin
      s_next.phase = ~s_reg.phase;
      if (!s_reg.phase) begin
        // rising edge: low nibble and valid
        s_next.rxd = rx_byte[3:0];
        s_next.rxctl = rx_valid;
        s_next.hi_hold = rx_byte[7:4];
        s_next.ctl_hold = rx_valid ^ rx_error;
        ev[pmp_pkg::EV_RX_ERR] = rx_valid & rx_error;
      end else begin
        // falling edge: high nibble and valid xor error
        s_next.rxd = s_reg.hi_hold;
        s_next.rxctl = s_reg.ctl_hold;
      end
    end else begin
      s_next.phase = 1'b0;
    end

    // sgmii: one serial bit per core clock on the output pair
    if (s_reg.strap_done && s_reg.sgmii) begin
      s_next.rxd_oe = 1'b1;
      s_next.ser_cnt = s_reg.ser_cnt + 3'h1;
      if (s_reg.ser_cnt == pmp_pkg::SER_LAST) begin
        s_next.ser_sh = rx_valid ? rx_byte : 8'h00;
        ev[pmp_pkg::EV_RX_ERR] = rx_valid & rx_error;
      end else begin
        s_next.ser_sh = {1'b0, s_reg.ser_sh[7:1]};
      end
      s_next.rxd = {~s_reg.ser_sh[0], s_reg.ser_sh[0], 2'h0};
    end

    // transmit path: byte crossing from link clock, or sgmii deserialiser
    s_next.txv = 1'b0;
    s_next.tgl_seen = s_reg.tgl_s[2];
    tx_evt = s_reg.tgl_s[2] ^ s_reg.tgl_seen;
    if (s_reg.sgmii) begin
      s_next.des_sh = {s_reg.sin_f, s_reg.des_sh[7:1]};
      s_next.des_cnt = s_reg.des_cnt + 3'h1;
      if (s_reg.des_cnt == pmp_pkg::SER_LAST) begin
        s_next.txb = {s_reg.sin_f, s_reg.des_sh[7:1]};
        s_next.txv = 1'b1;
        s_next.txe = 1'b0;
      end
    end else if (tx_evt) begin
      s_next.txb = txi.data;
      s_next.txv = txi.en;
      s_next.txe = txi.er;
      ev[pmp_pkg::EV_TX_ERR] = txi.er;
    end

    // management frame engine, advanced on each station clock rise
    if (mdc_rise) begin
      case (s_reg.st)
        pmp_pkg::MD_PRE: begin
          if (s_reg.mdio_f) begin
            if (s_reg.cnt != pmp_pkg::PREAMBLE_LEN) begin
              s_next.cnt = s_reg.cnt + 6'h01;
            end
          end else if (s_reg.cnt == pmp_pkg::PREAMBLE_LEN) begin
            s_next.st = pmp_pkg::MD_HDR;
            s_next.cnt = 6'h01;
            s_next.sh = 16'h0000;
          end else begin
            s_next.cnt = 6'h00;
          end
        end
        pmp_pkg::MD_HDR: begin
          hdr = {s_reg.sh[14:0], s_reg.mdio_f};
          s_next.sh = hdr;
          s_next.cnt = s_reg.cnt + 6'h01;
          if (s_reg.cnt + 6'h01 == pmp_pkg::HDR_BITS) begin
            s_next.cnt = 6'h00;
            s_next.reg_addr = hdr[4:0];
            s_next.rd_op = (hdr[11:10] == pmp_pkg::OP_READ);
            if (hdr[13:12] == pmp_pkg::FRAME_START && hdr[9:5] == my_addr &&
                (hdr[11:10] == pmp_pkg::OP_READ || hdr[11:10] == pmp_pkg::OP_WRITE)) begin
              s_next.st = pmp_pkg::MD_TA;
            end else begin
              s_next.st = pmp_pkg::MD_PRE;
            end
          end
        end
        pmp_pkg::MD_TA: begin
          // first turnaround bit released, second driven low on reads
          if (s_reg.cnt == 6'h00) begin
            s_next.cnt = 6'h01;
            s_next.mdoe = s_reg.rd_op;
            s_next.mdo = 1'b0;
          end else begin
            s_next.cnt = 6'h00;
            if (s_reg.rd_op) begin
              s_next.st = pmp_pkg::MD_RD;
              s_next.sh = reg_read(s_reg, s_reg.reg_addr);
              // open drain: a one is sent by releasing the line
              s_next.mdoe = ~s_next.sh[15];
              s_next.sh = {s_next.sh[14:0], 1'b0};
            end else begin
              s_next.st = pmp_pkg::MD_WR;
            end
          end
        end
        pmp_pkg::MD_RD: begin
          s_next.cnt = s_reg.cnt + 6'h01;
          if (s_reg.cnt + 6'h01 == pmp_pkg::DATA_BITS) begin
            s_next.mdoe = 1'b0;
            s_next.mdo = 1'b0;
            s_next.cnt = 6'h00;
            s_next.st = pmp_pkg::MD_PRE;
          end else begin
            s_next.mdoe = ~s_reg.sh[15];
            s_next.sh = {s_reg.sh[14:0], 1'b0};
          end
        end
        pmp_pkg::MD_WR: begin
          hdr = {s_reg.sh[14:0], s_reg.mdio_f};
          s_next.sh = hdr;
          s_next.cnt = s_reg.cnt + 6'h01;
          if (s_reg.cnt + 6'h01 == pmp_pkg::DATA_BITS) begin
            s_next.cnt = 6'h00;
            s_next.st = pmp_pkg::MD_PRE;
            case (s_reg.reg_addr)
              pmp_pkg::REG_INT_CTRL: begin
                s_next.int_en = hdr[pmp_pkg::INT_EN_LSB +: pmp_pkg::NUM_EVENTS];
                s_next.int_pol = hdr[pmp_pkg::INT_POL_BIT];
              end
              pmp_pkg::REG_INT_STAT: clr = hdr[pmp_pkg::NUM_EVENTS-1:0];
              pmp_pkg::REG_PWR_CTRL: begin
                if (hdr[pmp_pkg::PWR_SLEEP_BIT]) begin
                  s_next.sleep = 1'b1;
                end
              end
              default: ;
            endcase
          end
        end
        default: begin
          s_next.st = pmp_pkg::MD_PRE;
          s_next.cnt = 6'h00;
          s_next.mdoe = 1'b0;
        end
      endcase
    end

    // wake pulse ends sleep
    if (wake_rise && s_reg.sleep) begin
      s_next.sleep = 1'b0;
      ev[pmp_pkg::EV_WAKE] = 1'b1;
    end

    // sticky events: only enabled sources latch, and a new event beats a clear
    s_next.int_stat = (s_reg.int_stat & ~clr) | (ev & s_reg.int_en);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.st <= pmp_pkg::MD_PRE;
      s_reg.int_en <= pmp_pkg::INT_EN_RST;
      s_reg.int_pol <= pmp_pkg::INT_POL_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign int_active = |(s_reg.int_stat & s_reg.int_en);

  // handshake and pin outputs
  assign rx_ready = s_reg.strap_done &
                    (s_reg.sgmii ? (s_reg.ser_cnt == pmp_pkg::SER_LAST) : ~s_reg.phase);
  assign tx_byte = s_reg.txb;
  assign tx_valid = s_reg.txv;
  assign tx_error = s_reg.txe;
  assign rx_clk_o = s_reg.phase;
  assign rx_d_o = s_reg.rxd;
  assign rx_d_oe = s_reg.rxd_oe;
  assign rx_ctl_o = s_reg.rxctl;
  assign rx_ctl_oe = s_reg.rxctl_oe;
  assign mdio_o = s_reg.mdo;
  assign mdio_oe = s_reg.mdoe;
  // open drain low by default, push-pull high when polarity is flipped
  assign interrupt_output_o = s_reg.int_pol & int_active;
  assign interrupt_output_oe = s_reg.int_pol | int_active;
  assign power_inhibit_output_o = 1'b1;
  assign power_inhibit_output_oe = ~s_reg.sleep;
endmodule : pmp_port
`default_nettype wire

// ### pmp_end.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ### pmp_checker.sv
`timescale 1ns/100ps
`default_nettype none
module pmp_checker (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // receive side
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic rx_error,
  input wire logic rx_ready,
  input wire logic rx_clk_o,
  input wire logic [3:0] rx_d_o,
  input wire logic rx_d_oe,
  input wire logic rx_ctl_o,
  input wire logic rx_ctl_oe,
  // other pins
  input wire logic tx_valid,
  input wire logic mdio_oe,
  input wire logic mdio_o,
  input wire logic interrupt_output_oe,
  input wire logic power_inhibit_output_o,
  input wire logic power_inhibit_output_oe,
  input wire logic wake
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0] held_byte;
  logic held_err;
  // byte and error taken at the last accepting edge
  always_ff @(posedge clk) begin
    if (rx_ready) begin
      held_byte <= rx_byte;
      held_err <= rx_error;
    end
  end
  a_rx_low_nibble: assert property (rx_ready && rx_valid && rx_ctl_oe |=>
    rx_clk_o && rx_ctl_o && rx_d_o == held_byte[3:0]) else $error("low nibble wrong");
  a_rx_high_nibble: assert property (rx_ready && rx_valid && rx_ctl_oe |=> ##1
    !rx_clk_o && rx_d_o == held_byte[7:4] && rx_ctl_o == !held_err)
    else $error("high nibble wrong");
  a_rx_clk_toggles: assert property (rx_ctl_oe && $past(rx_ctl_oe) |->
    rx_clk_o != $past(rx_clk_o)) else $error("rx clock stalled");
  a_rx_drive_pair: assert property (rx_ctl_oe |-> rx_d_oe)
    else $error("ctl driven without data");
  a_int_quiet_start: assert property ($rose(resetn) |-> !interrupt_output_oe [*8])
    else $error("interrupt after reset");
  a_mdio_quiet_start: assert property ($rose(resetn) |-> !mdio_oe [*8])
    else $error("mdio driven after reset");
  a_inh_drives_high: assert property (power_inhibit_output_oe |-> power_inhibit_output_o)
    else $error("inhibit driven low");
  a_wake_leaves_sleep: assert property ($rose(wake) |-> ##[1:10] power_inhibit_output_oe)
    else $error("no wake");
  a_tx_valid_pulse: assert property (tx_valid |=> !tx_valid)
    else $error("tx valid too long");
  a_mdio_open_drain: assert property (mdio_oe |-> !mdio_o)
    else $error("mdio driven high");
endmodule : pmp_checker
bind pmp_port pmp_checker u_pmp_checker (.clk(clk), .resetn(resetn), .rx_byte(rx_byte),
  .rx_valid(rx_valid), .rx_error(rx_error), .rx_ready(rx_ready), .rx_clk_o(rx_clk_o),
  .rx_d_o(rx_d_o), .rx_d_oe(rx_d_oe), .rx_ctl_o(rx_ctl_o), .rx_ctl_oe(rx_ctl_oe),
  .tx_valid(tx_valid), .mdio_oe(mdio_oe), .mdio_o(mdio_o),
  .interrupt_output_oe(interrupt_output_oe),
  .power_inhibit_output_o(power_inhibit_output_o),
  .power_inhibit_output_oe(power_inhibit_output_oe), .wake(wake));
`default_nettype wire

// ### pmp_mac_model.sv
`timescale 1ns/100ps
`default_nettype none
module pmp_mac_model (
  // rgmii transmit toward the device
  output logic tx_clk,
  output logic tx_ctl,
  output logic [3:0] tx_d,
  // management station
  output logic mdc,
  output logic mdio_i,
  input wire logic mdio_o,
  input wire logic mdio_oe
);
  logic drv;
  // pulled-up shared line
  assign mdio_i = drv & (mdio_oe ? mdio_o : 1'b1);
  initial begin
    tx_clk = 1'b0;
    tx_ctl = 1'b0;
    tx_d = 4'h0;
    mdc = 1'b0;
    drv = 1'b1;
    #7;
    forever #40 tx_clk = ~tx_clk;
  end
  task automatic send_byte(input logic [7:0] d, input logic en, input logic er);
    @(negedge tx_clk);
    #2 tx_ctl = en;
    tx_d = d[3:0];
    @(posedge tx_clk);
    #2 tx_ctl = en ^ er;
    tx_d = d[7:4];
    @(negedge tx_clk);
    #2 tx_ctl = 1'b0;
    tx_d = ~d[7:4];
  endtask : send_byte
  task automatic mgmt(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [64:0] fr;
    fr = {32'hffffffff, pmp_pkg::FRAME_START, op, phy, ra,
          (op == pmp_pkg::OP_WRITE) ? {2'h2, wd} : 18'h3ffff, 1'b1};
    rd = 16'h0;
    for (int k = 64; k >= 0; k--) begin
      drv = fr[k];
      #200;
      // trailing idle bit carries no data
      if (k > 0) begin
        rd = {rd[14:0], mdio_i};
      end
      mdc = 1'b1;
      #200;
      mdc = 1'b0;
    end
  endtask : mgmt
endmodule : pmp_mac_model
`default_nettype wire

// ### phy_mac_port_and_control_pins_bench.sv
`timescale 1ns/100ps
`default_nettype none
module phy_mac_port_and_control_pins_bench;
  localparam logic [1:0] WR = pmp_pkg::OP_WRITE;
  localparam logic [1:0] RD = pmp_pkg::OP_READ;
  localparam logic [4:0] PHY0 = {pmp_pkg::ADDR_HI, 1'b0};
  // 10 us of low reset at 20 ns per cycle
  localparam int RST_HOLD = 500;
  logic clk, resetn, rx_valid, rx_error, rx_ready, tx_valid, tx_error, rx_clk_o;
  logic rx_d_oe, rx_ctl_o, rx_ctl_oe, tx_clk, tx_ctl, mdc, mdio_i, mdio_o, mdio_oe;
  logic int_o, int_oe, inh_o, inh_oe, wake, strap, rx_ctl_pin, sgmii_strap;
  logic [7:0] rx_byte, tx_byte;
  logic [3:0] rx_d_o, tx_d;
  logic [15:0] rd;
  int num_errors = 0;
  int check_count = 0;
  initial clk = 1'b0;
  always #10 clk = ~clk; // stands in for the reference clock
  // shared strap pin, pulled down unless the serial strap is fitted
  assign rx_ctl_pin = rx_ctl_oe ? rx_ctl_o : sgmii_strap;
  pmp_port u_pmp_port (.clk(clk), .resetn(resetn), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_error(rx_error), .rx_ready(rx_ready), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_error(tx_error), .rx_clk_o(rx_clk_o), .rx_d_o(rx_d_o), .rx_d_oe(rx_d_oe),
    .rx_ctl_i(rx_ctl_pin), .rx_ctl_o(rx_ctl_o), .rx_ctl_oe(rx_ctl_oe), .tx_clk(tx_clk),
    .tx_ctl(tx_ctl), .tx_d(tx_d), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .interrupt_output_o(int_o), .interrupt_output_oe(int_oe),
    .power_inhibit_output_o(inh_o), .power_inhibit_output_oe(inh_oe), .wake(wake),
    .first_strap_pin(strap));
  pmp_mac_model u_pmp_mac_model (.tx_clk(tx_clk), .tx_ctl(tx_ctl), .tx_d(tx_d), .mdc(mdc),
    .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic do_reset(input logic s, input int n);
    @(negedge clk);
    resetn = 1'b0;
    strap = s;
    repeat (n) @(negedge clk);
    check({rx_d_oe, int_oe, mdio_oe, inh_oe}, 16'h1);
    resetn = 1'b1;
    repeat (10) @(negedge clk);
  endtask : do_reset
  task automatic rx_test(input logic [7:0] b, input logic er);
    int n;
    @(negedge clk);
    rx_byte = b;
    rx_valid = 1'b1;
    rx_error = er;
    n = 0;
    while (rx_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    rx_valid = 1'b0;
    check({rx_clk_o, rx_ctl_o, rx_d_o}, {2'h3, b[3:0]});
    @(negedge clk);
    check({rx_clk_o, rx_ctl_o, rx_d_o}, {1'b0, !er, b[7:4]});
  endtask : rx_test
  task automatic tx_test(input logic [7:0] b, input logic er);
    int n;
    u_pmp_mac_model.send_byte(b, 1'b1, er);
    n = 0;
    while (tx_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check({tx_valid, tx_error, tx_byte}, {1'b1, er, b});
  endtask : tx_test
  task automatic int_test();
    rx_test(8'h3c, 1'b1);
    repeat (4) @(negedge clk);
    check(int_oe, 1'b0);
    u_pmp_mac_model.mgmt(WR, PHY0, pmp_pkg::REG_INT_CTRL, 16'h0001, rd);
    rx_test(8'hc3, 1'b1);
    repeat (4) @(negedge clk);
    check({int_oe, int_o}, 2'h2);
    u_pmp_mac_model.mgmt(WR, PHY0, pmp_pkg::REG_INT_CTRL, 16'h0011, rd);
    check({int_oe, int_o}, 2'h3);
    u_pmp_mac_model.mgmt(WR, PHY0, pmp_pkg::REG_INT_STAT, 16'h0001, rd);
    check({int_oe, int_o}, 2'h2);
    u_pmp_mac_model.mgmt(RD, PHY0, pmp_pkg::REG_INT_CTRL, 16'h0, rd);
    check(rd, 16'h0011);
  endtask : int_test
  task automatic sleep_test();
    u_pmp_mac_model.mgmt(WR, PHY0, pmp_pkg::REG_PWR_CTRL, 16'h0001, rd);
    check({inh_oe, inh_o}, 2'h1);
    @(negedge clk);
    wake = 1'b1;
    repeat (2) @(negedge clk);
    wake = 1'b0;
    repeat (10) @(negedge clk);
    check({inh_oe, inh_o}, 2'h3);
  endtask : sleep_test
  task automatic strap_test();
    do_reset(1'b1, RST_HOLD);
    u_pmp_mac_model.mgmt(RD, PHY0 | 5'h1, pmp_pkg::REG_INT_CTRL, 16'h0, rd);
    check(rd, 16'h0000);
    u_pmp_mac_model.mgmt(RD, PHY0, pmp_pkg::REG_INT_CTRL, 16'h0, rd);
    check(rd, 16'hffff);
  endtask : strap_test
  task automatic sgmii_test(input logic [7:0] b);
    int n;
    sgmii_strap = 1'b1;
    do_reset(1'b0, 3);
    u_pmp_mac_model.mgmt(RD, PHY0, pmp_pkg::REG_PWR_CTRL, 16'h0, rd);
    check(rd, 16'h0002);
    @(negedge clk);
    rx_byte = b;
    rx_valid = 1'b1;
    rx_error = 1'b0;
    n = 0;
    while (rx_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    rx_valid = 1'b0;
    // one bit per cycle, lsb first, with its inverse beside it
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      check({rx_clk_o, rx_ctl_oe, rx_d_o}, {2'h0, ~b[k], b[k], 2'h0});
    end
  endtask : sgmii_test
  initial begin
    resetn = 1'b0;
    rx_byte = 8'h0;
    rx_valid = 1'b0;
    rx_error = 1'b0;
    wake = 1'b0;
    strap = 1'b0;
    sgmii_strap = 1'b0;
    do_reset(1'b0, 3);
    rx_test(8'ha5, 1'b0);
    rx_test(8'h5a, 1'b1);
    tx_test(8'h96, 1'b0);
    tx_test(8'h69, 1'b1);
    int_test();
    sleep_test();
    strap_test();
    sgmii_test(8'hb4);
    finish_test();
  end
  // hang guard, well beyond the expected run
  initial begin
    #1ms;
    num_errors++;
    finish_test();
  end
endmodule : phy_mac_port_and_control_pins_bench
`default_nettype wire
